// ===== bench/flow_sched_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "flow_sched_consts.svh"
module flow_sched_checker (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic HDR_VALID,
  input wire flow_sched_pkg::ugsh_t HDR_UGSH,
  input wire logic GRANT_STB,
  input wire logic [15:0] GRANT_BYTES,
  input wire logic POLL_STB,
  input wire logic DSA_OUT_STB,
  input wire flow_sched_pkg::dsa_msg_t DSA_OUT_MSG
);
  import flow_sched_pkg::*;
  logic acc;
  logic [1:0] ctrl_q;
  logic [1:0] quiet;
  logic [7:0] seen_hdr;
  assign acc = PSEL && PENABLE;
  // ----
  // helper state
  // ----
  // strobes already in flight need a few cycles to drain after a mode write
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      ctrl_q <= 2'h0;
      quiet <= 2'h3;
    end else if (acc && PWRITE && PADDR == `OFS_CTRL) begin
      ctrl_q <= PWDATA[1:0];
      quiet <= 2'h0;
    end else if (quiet != 2'h3) begin
      quiet <= quiet + 2'h1;
    end
  end
  // latest header fields, in status order
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      seen_hdr <= 8'h00;
    end else if (HDR_VALID) begin
      seen_hdr <= {HDR_UGSH.active_grants, HDR_UGSH.qi};
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  // ----
  // properties
  // ----
  AST_APB_READY: assert property (acc |-> PREADY) else $error("access without ready");
  AST_HOLE: assert property (acc && !PWRITE && PADDR > `OFS_DSA |-> PSLVERR && PRDATA == 32'h00000000)
    else $error("unmapped read not refused");
  AST_MAPPED: assert property (acc && PADDR <= `OFS_DSA |-> !PSLVERR) else $error("mapped access refused");
  AST_DSA_CAUSE: assert property (DSA_OUT_STB |-> $past(acc && PWRITE && PADDR == `OFS_DSA))
    else $error("addition message without write");
  AST_DSA_SINGLE: assert property (DSA_OUT_STB |=> !DSA_OUT_STB) else $error("double message");
  AST_DSA_REQ: assert property (DSA_OUT_STB && DSA_OUT_MSG == MSG_REQ |-> $past(PWDATA[2:0]) == 3'h5)
    else $error("request sent without headend start");
  AST_DSA_RSP: assert property (DSA_OUT_STB && DSA_OUT_MSG == MSG_RSP |-> $past(PWDATA[2:0]) == 3'h1)
    else $error("response sent without modem request");
  AST_DSA_ACK: assert property (DSA_OUT_STB && DSA_OUT_MSG == MSG_ACK |-> $past(PWDATA[1:0]) == 2'h2)
    else $error("ack sent without response");
  AST_NO_POLL_UGS: assert property (quiet == 2'h3 && !ctrl_q[1] |-> !POLL_STB)
    else $error("poll in grant mode");
  AST_OFF_QUIET: assert property (quiet == 2'h3 && !ctrl_q[0] |-> !GRANT_STB && !POLL_STB)
    else $error("strobe while disabled");
  AST_GRANT_SIZE: assert property (GRANT_STB && $past(GRANT_STB) |-> $stable(GRANT_BYTES))
    else $error("grant size changed");
  AST_STATUS_HDR: assert property (acc && !PWRITE && PADDR == `OFS_STATUS |-> PRDATA[11:4] == $past(seen_hdr))
    else $error("status header fields stale");
endmodule
bind flow_sched flow_sched_checker flow_sched_checker_i (.REF_CLK, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR,
  .PWDATA, .PRDATA, .PREADY, .PSLVERR, .HDR_VALID, .HDR_UGSH, .GRANT_STB, .GRANT_BYTES, .POLL_STB,
  .DSA_OUT_STB, .DSA_OUT_MSG);
`default_nettype wire

// ===== bench/flow_sched_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "flow_sched_consts.svh"
module flow_sched_test;
  import flow_sched_pkg::*;
  logic ref_clk, pready, pslverr, hdr_valid, grant_stb, poll_stb, dsa_out_stb, err;
  logic resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, over_limit = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic [15:0] grant_bytes;
  logic [6:0] need = 7'h05;
  logic [7:0] gap = 8'h08;
  ugsh_t hdr_ugsh;
  dsa_msg_t dsa_out_msg, last_msg;
  int error_cnt = 0, n_tests = 0, n_grant = 0, n_poll = 0, n_dsa = 0, g, p;
  // adm, act, cmd, status, adm readback, act readback, rule counts
  logic [31:0] chg [9][7] = '{
    '{32'h20040, 32'h20040, 32'h06, 32'h6, 32'h20040, 32'h20040, 32'h0000},
    '{32'h20040, 32'h30040, 32'h06, 32'hA, 32'h20040, 32'h20040, 32'h0000},
    '{32'h7FFFFF, 32'h10001, 32'h06, 32'hA, 32'h20040, 32'h20040, 32'h0000},
    '{32'h10020, 32'h10020, 32'h02, 32'h5, 32'h10020, 32'h00000, 32'h0000},
    '{32'h10020, 32'h10020, 32'h00, 32'h4, 32'h00000, 32'h00000, 32'h0000},
    '{32'h20040, 32'h20040, 32'h03, 32'h8, 32'h00000, 32'h00000, 32'h0000},
    '{32'h20040, 32'h20040, 32'h2E, 32'h6, 32'h20040, 32'h20040, 32'h0101},
    '{32'h20040, 32'h20040, 32'h56, 32'h6, 32'h20040, 32'h20040, 32'h0101},
    '{32'h20040, 32'h20040, 32'h7E, 32'h6, 32'h20040, 32'h20040, 32'h0000}};
  // bind write, read mask, expected read
  logic [31:0] bnd [5][3] = '{
    '{32'h00001111, 32'hFFFFFFFF, 32'h81011111}, '{32'h00012222, 32'h80FFFFFF, 32'h00022222},
    '{32'h00023333, 32'h80FFFFFF, 32'h00033333}, '{32'h00034444, 32'h80FFFFFF, 32'h00044444},
    '{32'h00005555, 32'hFFFFFFFF, 32'h82055555}};
  flow_sched flow_sched_i (.REF_CLK(ref_clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .HDR_VALID(hdr_valid),
    .HDR_UGSH(hdr_ugsh), .GRANT_STB(grant_stb), .GRANT_BYTES(grant_bytes), .POLL_STB(poll_stb),
    .DSA_OUT_STB(dsa_out_stb), .DSA_OUT_MSG(dsa_out_msg));
  modem_model modem_model_i (.clk(ref_clk), .resetn(resetn), .over_limit(over_limit), .need(need), .gap(gap),
    .hdr_valid(hdr_valid), .hdr(hdr_ugsh));
  // ----
  // clock and strobe counters
  // ----
  initial begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end
  // strobes last one cycle, so count them at every edge
  always @(posedge ref_clk) begin
    if (grant_stb === 1'h1) n_grant++;
    if (poll_stb === 1'h1) n_poll++;
    if (dsa_out_stb === 1'h1) begin
      n_dsa++;
      last_msg = dsa_out_msg;
    end
  end
  // ----
  // tasks
  // ----
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      error_cnt++;
    end
  endtask
  // request held until ready is sampled high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] mask);
    apb(1'h0, a, 32'h00000000);
    check(rd & mask, exp);
  endtask
  // window starts just after a burst, so it holds whole bursts only
  task automatic window(input logic pl, input int cyc);
    int n;
    int g0;
    int p0;
    for (int ph = 0; ph < 2; ph++) begin
      n = 0;
      while (((pl ? poll_stb : grant_stb) === 1'h1) == (ph == 1) && n < 3000) begin
        @(posedge ref_clk);
        n++;
      end
      if (n >= 3000) begin
        error_cnt++;
        stop_test();
      end
    end
    #1;
    g0 = n_grant;
    p0 = n_poll;
    repeat (cyc) @(posedge ref_clk);
    #1;
    g = n_grant - g0;
    p = n_poll - p0;
  endtask
  // ----
  // tests
  // ----
  initial begin
    repeat (12) @(posedge ref_clk);
    resetn <= 1'h1;
    rdchk(`OFS_GRANT_INT, {16'h0000, `INT_RESET}, 32'hFFFFFFFF);
    rdchk(`OFS_POLL_INT, {16'h0000, `POLL_RESET}, 32'hFFFFFFFF);
    rdchk(`OFS_CAPACITY, {8'h00, `CAP_RESET}, 32'hFFFFFFFF);
    rdchk(12'h040, 32'h00000000, 32'hFFFFFFFF);
    check({31'h0, err}, 32'h00000001);
    $display("test reset done");
    foreach (chg[i]) begin
      apb(1'h1, `OFS_CHG_ADM, chg[i][0]);
      apb(1'h1, `OFS_CHG_ACT, chg[i][1]);
      apb(1'h1, `OFS_CHG_CMD, chg[i][2]);
      rdchk(`OFS_STATUS, chg[i][3], 32'h0000000F);
      rdchk(`OFS_ADM_SET, chg[i][4], 32'hFFFFFFFF);
      rdchk(`OFS_ACT_SET, chg[i][5], 32'hFFFFFFFF);
      rdchk(`OFS_RULES, chg[i][6], 32'h0000FFFF);
    end
    $display("test change done");
    foreach (bnd[i]) begin
      apb(1'h1, `OFS_REG_BIND, bnd[i][0]);
      rdchk(`OFS_REG_BIND, bnd[i][2], bnd[i][1]);
    end
    $display("test bind done");
    apb(1'h1, `OFS_DSA, 32'h03);
    rdchk(`OFS_STATUS, 32'h0000, 32'h3000);
    check(n_dsa, 0);
    apb(1'h1, `OFS_DSA, 32'h1D);
    rdchk(`OFS_STATUS, 32'h1000, 32'h3000);
    check(last_msg, MSG_REQ);
    apb(1'h1, `OFS_DSA, 32'h02);
    rdchk(`OFS_STATUS, 32'h4000, 32'h7000);
    check(last_msg, MSG_ACK);
    rdchk(`OFS_DSA, 32'h0706, 32'hFFFF);
    apb(1'h1, `OFS_DSA, 32'h19);
    rdchk(`OFS_STATUS, 32'h2000, 32'h3000);
    check(last_msg, MSG_RSP);
    apb(1'h1, `OFS_DSA, 32'h03);
    rdchk(`OFS_STATUS, 32'h4000, 32'h7000);
    rdchk(`OFS_DSA, 32'h0908, 32'hFFFF);
    check(n_dsa, 3);
    $display("test addition done");
    apb(1'h1, `OFS_GRANT_INT, 32'h20);
    apb(1'h1, `OFS_CTRL, 32'h1);
    window(1'h0, 320);
    check(g, 20);
    check(p, 0);
    check(grant_bytes, 32'h40);
    over_limit <= 1'h1;
    repeat (20) @(posedge ref_clk);
    rdchk(`OFS_STATUS, 32'h0B0, 32'hFF0);
    // long enough for the bucket to earn at least one surplus grant
    window(1'h0, 3200);
    check(g > 200 && g <= (100 * 128 * 101 / 100 + 3 * 128) / 64, 1);
    over_limit <= 1'h0;
    gap <= 8'h3C;
    repeat (70) @(posedge ref_clk);
    window(1'h0, 320);
    check(g, 20);
    $display("test grants done");
    apb(1'h1, `OFS_POLL_INT, 32'h10);
    apb(1'h1, `OFS_CTRL, 32'h3);
    window(1'h1, 160);
    check(p, 10);
    check(g, 0);
    apb(1'h1, `OFS_CTRL, 32'h0);
    repeat (4) @(posedge ref_clk);
    g = n_grant;
    p = n_poll;
    repeat (200) @(posedge ref_clk);
    check(n_grant - g, 0);
    check(n_poll - p, 0);
    $display("test polling done");
    stop_test();
  end
endmodule
`default_nettype wire

// ===== bench/modem_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// far-side modem: one header per packet
// ----
module modem_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic over_limit,
  input wire logic [6:0] need,
  input wire logic [7:0] gap,
  output var logic hdr_valid,
  output var flow_sched_pkg::ugsh_t hdr
);
  import flow_sched_pkg::*;
  logic [7:0] cnt;
  // sends no contention, request/data or piggyback requests at all
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt <= 8'h00;
      hdr_valid <= 1'h0;
      hdr <= '0;
    end else if (cnt >= gap) begin
      cnt <= 8'h00;
      hdr_valid <= 1'h1;
      hdr.qi <= over_limit;
      hdr.active_grants <= need;
    end else begin
      cnt <= cnt + 8'h01;
      hdr_valid <= 1'h0;
      hdr <= ~hdr; // field not held between packets
    end
  end
endmodule
`default_nettype wire

// ===== logic/flow_sched.sv
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "flow_sched_consts.svh"

module flow_sched (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic HDR_VALID,
  input wire flow_sched_pkg::ugsh_t HDR_UGSH,
  output logic GRANT_STB,
  output logic [15:0] GRANT_BYTES,
  output logic POLL_STB,
  output logic DSA_OUT_STB,
  output flow_sched_pkg::dsa_msg_t DSA_OUT_MSG
);
  import flow_sched_pkg::*;

  // ----------------------------------------
  // register bus decode
  // ----------------------------------------
  logic wr_en;
  logic rd_setup;
  logic mapped;
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_setup = PSEL && !PENABLE;
  assign PREADY = PENABLE;
  always_comb begin
    unique case (PADDR)
      `OFS_CTRL, `OFS_GRANT_INT, `OFS_POLL_INT, `OFS_CAPACITY, `OFS_CHG_ADM, `OFS_CHG_ACT,
      `OFS_CHG_CMD, `OFS_STATUS, `OFS_ADM_SET, `OFS_ACT_SET, `OFS_RULES, `OFS_REG_BIND,
      `OFS_DSA: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  // unmapped addresses answer with an error, reads give zero
  assign PSLVERR = PSEL && PENABLE && !mapped;

  // ----------------------------------------
  // software-written configuration
  // ----------------------------------------
  logic sched_en;
  logic polling_mode;
  logic [15:0] grant_int;
  logic [15:0] poll_int;
  logic [23:0] capacity;
  qos_set_t chg_adm;
  qos_set_t chg_act;
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      sched_en <= 1'b0;
      polling_mode <= 1'b0;
      grant_int <= `INT_RESET;
      poll_int <= `POLL_RESET;
      capacity <= `CAP_RESET;
      chg_adm <= '0;
      chg_act <= '0;
    end else if (wr_en) begin
      unique case (PADDR)
        `OFS_CTRL: begin
          sched_en <= PWDATA[0];
          polling_mode <= PWDATA[1];
        end
        `OFS_GRANT_INT: grant_int <= PWDATA[15:0];
        `OFS_POLL_INT: poll_int <= PWDATA[15:0];
        `OFS_CAPACITY: capacity <= PWDATA[23:0];
        `OFS_CHG_ADM: chg_adm <= PWDATA[22:0];
        `OFS_CHG_ACT: chg_act <= PWDATA[22:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // change transaction
  // ----------------------------------------
  qos_set_t adm_set;
  qos_set_t act_set;
  flow_state_t flow_state;
  logic [1:0] chg_result;
  logic chg_go;
  logic [2:0] set_type;
  logic admit_ok;
  logic subset_ok;
  logic [22:0] adm_bytes;
  assign chg_go = wr_en && (PADDR == `OFS_CHG_CMD);
  assign set_type = PWDATA[2:0];
  // operands widened first so the product keeps all 23 bits
  assign adm_bytes = {7'h00, chg_adm.grant_size} * {16'h0000, chg_adm.gpi};
  assign admit_ok = {1'b0, adm_bytes} <= capacity;
  assign subset_ok = (chg_act.gpi <= chg_adm.gpi) && (chg_act.grant_size <= chg_adm.grant_size);

  // admission is judged before the subset test; any failure leaves both sets
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      adm_set <= '0;
      act_set <= '0;
      flow_state <= FLOW_DEADMITTED;
      chg_result <= `RES_NONE;
    end else if (chg_go) begin
      unique case (set_type)
        `SET_TYPE_NONE: begin
          adm_set <= '0;
          act_set <= '0;
          flow_state <= FLOW_DEADMITTED;
          chg_result <= `RES_OK;
        end
        `SET_TYPE_ADM: begin
          if (admit_ok) begin
            adm_set <= chg_adm;
            act_set <= '0;
            flow_state <= FLOW_ADMITTED;
            chg_result <= `RES_OK;
          end else begin
            chg_result <= `RES_FAIL;
          end
        end
        `SET_TYPE_BOTH: begin
          if (admit_ok && subset_ok) begin
            adm_set <= chg_adm;
            act_set <= chg_act;
            flow_state <= FLOW_ACTIVE;
            chg_result <= `RES_OK;
          end else begin
            chg_result <= `RES_FAIL;
          end
        end
        default: chg_result <= `RES_FAIL;
      endcase
    end
  end

  // classifier and suppression rule counts edited alongside a change
  logic [7:0] class_cnt;
  logic [7:0] phs_cnt;
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      class_cnt <= 8'h00;
      phs_cnt <= 8'h00;
    end else if (chg_go) begin
      if (PWDATA[4:3] == `EDIT_ADD) begin
        class_cnt <= class_cnt + 8'h01;
      end else if (PWDATA[4:3] == `EDIT_DEL && class_cnt != 8'h00) begin
        class_cnt <= class_cnt - 8'h01;
      end
      if (PWDATA[6:5] == `EDIT_ADD) begin
        phs_cnt <= phs_cnt + 8'h01;
      end else if (PWDATA[6:5] == `EDIT_DEL && phs_cnt != 8'h00) begin
        phs_cnt <= phs_cnt - 8'h01;
      end
    end
  end

  // ----------------------------------------
  // identifier binding: registration and addition
  // ----------------------------------------
  bind_req_t bind_req;
  bind_rsp_t bind_rsp;
  logic [15:0] bind_ref;
  logic reg_go;
  logic dsa_go;
  bind_kind_t reg_kind;
  dsa_msg_t dsa_msg_in;
  logic dsa_he_init;
  dsa_state_t dsa_state;
  logic dsa_done;
  assign reg_go = wr_en && (PADDR == `OFS_REG_BIND);
  assign dsa_go = wr_en && (PADDR == `OFS_DSA);
  assign reg_kind = bind_kind_t'(PWDATA[17:16]);
  assign dsa_msg_in = dsa_msg_t'(PWDATA[1:0]);
  assign dsa_he_init = PWDATA[2];

  // active upstream gets both ids, provisioned upstream and downstream only a flow id
  always_comb begin
    bind_req = '0;
    if (reg_go) begin
      bind_req.valid = 1'b1;
      bind_req.want_us = (reg_kind == BIND_ACTIVE_US) || (reg_kind == BIND_PROV_US);
      bind_req.want_ds = (reg_kind == BIND_ACTIVE_DS) || (reg_kind == BIND_PROV_DS);
      bind_req.want_sid = (reg_kind == BIND_ACTIVE_US);
    end else if (dsa_go && dsa_msg_in == MSG_REQ && dsa_state == DSA_IDLE && (PWDATA[3] || PWDATA[4])) begin
      // one upstream bit and one downstream bit: never more than one of each
      bind_req.valid = 1'b1;
      bind_req.want_us = PWDATA[3];
      bind_req.want_ds = PWDATA[4];
      bind_req.want_sid = PWDATA[3];
    end
  end

  id_binder id_binder_i (
    .clk(REF_CLK),
    .resetn(RESETN),
    .req(bind_req),
    .rsp(bind_rsp)
  );

  // reference echoed untouched next to the assigned ids
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      bind_ref <= 16'h0000;
    end else if (reg_go) begin
      bind_ref <= PWDATA[15:0];
    end
  end

  // addition handshake; a modem request is answered by us, ours awaits its answer
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      dsa_state <= DSA_IDLE;
      dsa_done <= 1'b0;
      DSA_OUT_STB <= 1'b0;
      DSA_OUT_MSG <= MSG_NONE;
    end else begin
      DSA_OUT_STB <= 1'b0;
      if (dsa_go) begin
        unique case (dsa_state)
          DSA_IDLE: begin
            if (dsa_msg_in == MSG_REQ && bind_req.valid) begin
              dsa_done <= 1'b0;
              DSA_OUT_STB <= 1'b1;
              if (dsa_he_init) begin
                DSA_OUT_MSG <= MSG_REQ;
                dsa_state <= DSA_WAIT_RSP;
              end else begin
                DSA_OUT_MSG <= MSG_RSP;
                dsa_state <= DSA_WAIT_ACK;
              end
            end
          end
          DSA_WAIT_RSP: begin
            if (dsa_msg_in == MSG_RSP) begin
              DSA_OUT_STB <= 1'b1;
              DSA_OUT_MSG <= MSG_ACK;
              dsa_done <= 1'b1;
              dsa_state <= DSA_IDLE;
            end
          end
          DSA_WAIT_ACK: begin
            if (dsa_msg_in == MSG_ACK) begin
              dsa_done <= 1'b1;
              dsa_state <= DSA_IDLE;
            end
          end
          default: dsa_state <= DSA_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // received header state
  // ----------------------------------------
  logic qi;
  logic [6:0] active_grants;
  // the latest header always wins; the grant count is only reported
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      qi <= 1'b0;
      active_grants <= 7'h00;
    end else if (HDR_VALID) begin
      qi <= HDR_UGSH.qi;
      active_grants <= HDR_UGSH.active_grants;
    end
  end

  // ----------------------------------------
  // grant and poll scheduling
  // ----------------------------------------
  logic flow_live;
  logic [15:0] int_cnt;
  logic [15:0] poll_cnt;
  logic int_tick;
  logic poll_tick;
  logic [6:0] pending;
  logic extra_used;
  logic [25:0] credit;
  logic [25:0] burst_b;
  logic [25:0] refill;
  logic [25:0] cap3;
  logic [25:0] next_credit;
  logic grant_now;
  logic want_extra;
  assign flow_live = sched_en && (flow_state == FLOW_ACTIVE);
  assign int_tick = flow_live && !polling_mode && (int_cnt == 16'h0000);
  assign poll_tick = flow_live && polling_mode && (poll_cnt == 16'h0000);
  assign burst_b = {10'h000, act_set.grant_size} * {19'h00000, act_set.gpi};
  assign refill = burst_b + ((burst_b * `EXTRA_MUL) >> `EXTRA_SHIFT);
  assign cap3 = 26'(burst_b * `BURST_MUL);
  assign want_extra = qi && !extra_used && (pending == 7'h00) && (credit >= {10'h000, act_set.grant_size});
  assign grant_now = !int_tick && ((pending != 7'h00) || want_extra);

  // interval counters restart at every period
  always_ff @(posedge REF_CLK) begin
    if (!RESETN || !flow_live) begin
      int_cnt <= 16'h0000;
      poll_cnt <= 16'h0000;
    end else begin
      int_cnt <= int_tick ? grant_int - 16'h0001 : int_cnt - {15'h0000, int_cnt != 16'h0000};
      poll_cnt <= poll_tick ? poll_int - 16'h0001 : poll_cnt - {15'h0000, poll_cnt != 16'h0000};
    end
  end

  // byte bucket refilled each interval, never above 3B
  always_comb begin
    next_credit = credit;
    if (int_tick) begin
      next_credit = (credit + refill > cap3) ? cap3 : credit + refill;
    end else if (grant_now) begin
      next_credit = (credit > {10'h000, act_set.grant_size}) ? credit - {10'h000, act_set.grant_size} : 26'h0000000;
    end
  end

  // nominal grants at the interval start, one surplus grant only while flagged
  always_ff @(posedge REF_CLK) begin
    if (!RESETN || !flow_live || polling_mode) begin
      pending <= 7'h00;
      extra_used <= 1'b0;
      credit <= 26'h0000000;
    end else begin
      credit <= next_credit;
      if (int_tick) begin
        pending <= act_set.gpi;
        extra_used <= 1'b0;
      end else if (pending != 7'h00) begin
        pending <= pending - 7'h01;
      end else if (want_extra) begin
        extra_used <= 1'b1;
      end
    end
  end

  // grants carry the fixed grant size; polls only for the polling flow
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      GRANT_STB <= 1'b0;
      GRANT_BYTES <= 16'h0000;
      POLL_STB <= 1'b0;
    end else begin
      GRANT_STB <= flow_live && !polling_mode && grant_now;
      GRANT_BYTES <= act_set.grant_size;
      POLL_STB <= poll_tick;
    end
  end

  // ----------------------------------------
  // read data, captured in the setup cycle
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      PRDATA <= 32'h00000000;
    end else if (rd_setup) begin
      unique case (PADDR)
        `OFS_CTRL: PRDATA <= {30'h00000000, polling_mode, sched_en};
        `OFS_GRANT_INT: PRDATA <= {16'h0000, grant_int};
        `OFS_POLL_INT: PRDATA <= {16'h0000, poll_int};
        `OFS_CAPACITY: PRDATA <= {8'h00, capacity};
        `OFS_CHG_ADM: PRDATA <= {9'h000, chg_adm};
        `OFS_CHG_ACT: PRDATA <= {9'h000, chg_act};
        `OFS_STATUS: PRDATA <= {17'h00000, dsa_done, dsa_state, active_grants, qi, chg_result, flow_state};
        `OFS_ADM_SET: PRDATA <= {9'h000, adm_set};
        `OFS_ACT_SET: PRDATA <= {9'h000, act_set};
        `OFS_RULES: PRDATA <= {16'h0000, phs_cnt, class_cnt};
        `OFS_REG_BIND: PRDATA <= {bind_rsp.sid_valid, bind_rsp.sid, bind_rsp.sfid_us | bind_rsp.sfid_ds, bind_ref};
        `OFS_DSA: PRDATA <= {bind_rsp.sid_valid, bind_rsp.sid, bind_rsp.sfid_ds, bind_rsp.sfid_us};
        default: PRDATA <= 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== logic/flow_sched_consts.svh
`ifndef FLOW_SCHED_CONSTS_SVH
`define FLOW_SCHED_CONSTS_SVH
// register byte offsets
`define OFS_CTRL 12'h000
`define OFS_GRANT_INT 12'h004
`define OFS_POLL_INT 12'h008
`define OFS_CAPACITY 12'h00C
`define OFS_CHG_ADM 12'h010
`define OFS_CHG_ACT 12'h014
`define OFS_CHG_CMD 12'h018
`define OFS_STATUS 12'h01C
`define OFS_ADM_SET 12'h020
`define OFS_ACT_SET 12'h024
`define OFS_RULES 12'h028
`define OFS_REG_BIND 12'h02C
`define OFS_DSA 12'h030
// parameter-set type codes carried by a change
`define SET_TYPE_NONE 3'h0
`define SET_TYPE_ADM 3'h2
`define SET_TYPE_BOTH 3'h6
// rule edit codes
`define EDIT_NONE 2'h0
`define EDIT_ADD 2'h1
`define EDIT_KEEP 2'h2
`define EDIT_DEL 2'h3
// change result codes
`define RES_NONE 2'h0
`define RES_OK 2'h1
`define RES_FAIL 2'h2
// reset values
`define INT_RESET 16'h0100
`define POLL_RESET 16'h0100
`define CAP_RESET 24'h000FFF
// surplus fraction of one interval's bytes: 5/512, just under one percent
`define EXTRA_MUL 26'h0000005
`define EXTRA_SHIFT 9
`define BURST_MUL 26'h0000003
`endif

// ===== logic/flow_sched_pkg.sv
package flow_sched_pkg;
  typedef struct packed {
    logic [6:0] gpi;
    logic [15:0] grant_size;
  } qos_set_t;
  typedef enum logic [1:0] {
    FLOW_DEADMITTED = 2'b00,
    FLOW_ADMITTED = 2'b01,
    FLOW_ACTIVE = 2'b10
  } flow_state_t;
  typedef enum logic [1:0] {
    DSA_IDLE = 2'b00,
    DSA_WAIT_RSP = 2'b01,
    DSA_WAIT_ACK = 2'b10
  } dsa_state_t;
  typedef enum logic [1:0] {
    MSG_NONE = 2'b00,
    MSG_REQ = 2'b01,
    MSG_RSP = 2'b10,
    MSG_ACK = 2'b11
  } dsa_msg_t;
  typedef enum logic [1:0] {
    BIND_ACTIVE_US = 2'b00,
    BIND_PROV_US = 2'b01,
    BIND_ACTIVE_DS = 2'b10,
    BIND_PROV_DS = 2'b11
  } bind_kind_t;
  typedef struct packed {
    logic valid;
    logic want_us;
    logic want_ds;
    logic want_sid;
  } bind_req_t;
  typedef struct packed {
    logic sid_valid;
    logic [6:0] sid;
    logic [7:0] sfid_ds;
    logic [7:0] sfid_us;
  } bind_rsp_t;
  typedef struct packed {
    logic qi;
    logic [6:0] active_grants;
  } ugsh_t;
endpackage

// ===== logic/id_binder.sv
`timescale 1ns/10ps
`default_nettype none
// hands out flow and service identifiers in ascending order
module id_binder (
  input wire logic clk,
  input wire logic resetn,
  input wire flow_sched_pkg::bind_req_t req,
  output flow_sched_pkg::bind_rsp_t rsp
);
  import flow_sched_pkg::*;

  logic [7:0] next_sfid;
  logic [6:0] next_sid;

  // counters wrap; software must retire flow ids before 256 and service ids before 128 are issued
  always_ff @(posedge clk) begin
    if (!resetn) begin
      next_sfid <= 8'h01;
      next_sid <= 7'h01;
    end else if (req.valid) begin
      next_sfid <= next_sfid + {7'h00, req.want_us} + {7'h00, req.want_ds};
      if (req.want_sid && req.want_us) begin
        next_sid <= next_sid + 7'h01;
      end
    end
  end

  // answer registered the edge after the request
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rsp <= '0;
    end else if (req.valid) begin
      rsp.sfid_us <= req.want_us ? next_sfid : 8'h00;
      rsp.sfid_ds <= req.want_ds ? (req.want_us ? next_sfid + 8'h01 : next_sfid) : 8'h00;
      rsp.sid_valid <= req.want_sid && req.want_us;
      rsp.sid <= (req.want_sid && req.want_us) ? next_sid : 7'h00;
    end
  end
endmodule
`default_nettype wire
